// File: pkg/sofp_pkg.sv
// constants and types for the serial output frame port
// assumes one aclk domain and an axi4-lite register bus
package sofp_pkg;
  localparam int SOFP_AW = 10;
  // register indexes; byte address is four times the index
  localparam logic [7:0] IDX_CFG = 8'ha9;
  localparam logic [7:0] IDX_EXT = 8'haa;
  localparam logic [7:0] IDX_STAT = 8'hab;
  localparam logic [9:0] ADDR_CFG = {IDX_CFG, 2'b00};
  localparam logic [9:0] ADDR_EXT = {IDX_EXT, 2'b00};
  localparam logic [9:0] ADDR_STAT = {IDX_STAT, 2'b00};
  // serial_port_config fields
  localparam int CFG_DIV_LSB = 0;
  localparam int CFG_MASTER_BIT = 4;
  localparam logic [4:0] CFG_RST = 5'h00;
  // frame options register fields
  localparam int EXT_MODE_LSB = 0;
  localparam int EXT_WLEN_LSB = 2;
  localparam logic [3:0] EXT_RST = 4'h0;
  // status register fields
  localparam int STAT_FULL_BIT = 0;
  localparam int STAT_MASTER_BIT = 1;
  localparam int STAT_STATE_LSB = 2;
  // pin vector layout for the synchronisers
  localparam int PIN_SCLK = 0;
  localparam int PIN_FS = 1;
  localparam int PIN_M0 = 2;
  localparam int PIN_DIV = 3;
  localparam int PIN_N = 7;
  // cycles after reset release before the port 0 strap is final
  localparam logic [2:0] STRAP_WAIT = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [4:0] BITS_12 = 5'h0c;
  localparam logic [4:0] BITS_16 = 5'h10;
  localparam logic [4:0] BITS_24 = 5'h18;

  typedef enum logic [1:0] {
    SOFP_FS_PRE = 2'b00,
    SOFP_FS_DURING = 2'b01,
    SOFP_FS_EACH = 2'b10
  } sofp_fsmode_t;

  typedef enum logic [1:0] {
    SOFP_ST_IDLE = 2'b00,
    SOFP_ST_SYNC = 2'b01,
    SOFP_ST_SHIFT = 2'b10
  } sofp_state_t;

  function automatic logic [4:0] sofp_word_bits(input logic [1:0] code);
    case (code)
      2'b00: sofp_word_bits = BITS_12;
      2'b01: sofp_word_bits = BITS_16;
      default: sofp_word_bits = BITS_24;
    endcase
  endfunction
endpackage

// File: hw/sofp_port.sv
// serial output frame port of one receiver channel, axi4-lite registers
// assumes results arrive on aclk; sclk and frame sync pins are async
//
// Behaviour
// - I then Q word, 12/16/24 bits, MSB first
// - pre mode: sync one sclk, then data
// - during mode: sync high while bits shift
// - each mode: sync before first I and Q
// - frame end high during Q LSB
// - frame end serves receiver or cascaded sync
// - data ready while serial buffer is full
// - cascade samples sync on sclk rising edge
// - shifting starts next rising edge after sync
// - master drives clock and sync, slave listens
// - port 0 master from strap at reset
// - ports 1-3 slave until bit written
// - sclk is aclk divided by word plus one; word 0 here divides by two
// - port 0 divider from dedicated pins
// - ports 1-3 divider in config bits 3:0
// - config bit 4 makes port master
// - each port configured on its own
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
module sofp_port #(
  parameter bit IS_PORT0 = 1'b0
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite slave
  input wire logic [sofp_pkg::SOFP_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [sofp_pkg::SOFP_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // results from the filter
  input wire logic res_valid,
  input wire logic [23:0] res_i,
  input wire logic [23:0] res_q,
  output logic res_ready,
  // port 0 straps
  input wire logic port0_master_pin,
  input wire logic [3:0] port0_divider_pins,
  // serial pins
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic frame_sync_i,
  output logic frame_sync_o,
  output logic frame_sync_oe,
  output logic serial_data_out,
  output logic frame_end,
  output logic channel_data_ready
);
  import sofp_pkg::*;

  logic [PIN_N-1:0] s1_q, s2_q, s3_q, pin_q;
  wire [PIN_N-1:0] pin_raw = {port0_divider_pins, port0_master_pin,
                              frame_sync_i, sclk_i};

  // a pin level counts only once the second and third stages agree
  for (genvar g = 0; g < PIN_N; g++) begin : g_sync
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        s1_q[g] <= 1'b0;
        s2_q[g] <= 1'b0;
        s3_q[g] <= 1'b0;
        pin_q[g] <= 1'b0;
      end else begin
        s1_q[g] <= pin_raw[g];
        s2_q[g] <= s1_q[g];
        s3_q[g] <= s2_q[g];
        if (s2_q[g] == s3_q[g]) begin
          pin_q[g] <= s3_q[g];
        end
      end
    end
  end

  logic [4:0] cfg_q;
  logic [3:0] ext_q;
  logic [2:0] strap_cnt_q;
  logic strap_q;
  // strap is caught after release, once the synchroniser has filled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strap_cnt_q <= 3'h0;
      strap_q <= 1'b0;
    end else if (strap_cnt_q != STRAP_WAIT) begin
      strap_cnt_q <= strap_cnt_q + 3'h1;
      strap_q <= pin_q[PIN_M0];
    end
  end

  wire master = IS_PORT0 ? strap_q : cfg_q[CFG_MASTER_BIT];
  wire [3:0] div = IS_PORT0 ? pin_q[PIN_DIV +: 4]
                            : cfg_q[CFG_DIV_LSB +: 4];
  // a pin cannot toggle at aclk itself, so divide by two at least
  wire [3:0] div_eff = (div == 4'h0) ? 4'h1 : div;
  wire [3:0] half = 4'((5'(div_eff) + 5'h01) >> 1);

  logic [3:0] div_cnt_q;
  wire m_tick = master && (div_cnt_q == div_eff);
  wire [3:0] div_cnt_d = m_tick ? 4'h0 : div_cnt_q + 4'h1;

  always_ff @(posedge aclk) begin
    if (!aresetn || !master) begin
      div_cnt_q <= 4'h0;
      sclk_o <= 1'b0;
    end else begin
      div_cnt_q <= div_cnt_d;
      sclk_o <= (div_cnt_d < half);
    end
  end

  wire s_tick = !master && s2_q[PIN_SCLK] && s3_q[PIN_SCLK] &&
                !pin_q[PIN_SCLK];
  wire tick = m_tick || s_tick;
  wire fs_in = pin_q[PIN_FS];
  sofp_state_t st_q, st_d;
  sofp_fsmode_t fmode_q, fmode_d;
  logic [5:0] cnt_q, cnt_d, nbd;
  logic [4:0] nbits_q, nbits_d;
  logic [23:0] ish_q, ish_d, qsh_q, qsh_d;
  logic full_q, full_d, sdo_n, fe_n, fs_n;
  wire [5:0] nb6 = {1'b0, nbits_q};
  wire [5:0] i_last = nb6 - 6'h01;
  wire [5:0] last_idx = {nbits_q, 1'b0} - 6'h01;
  // cascade start waits for the partner's sync on an sclk rise
  wire go = full_q && (master || fs_in);
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    ish_d = ish_q;
    qsh_d = qsh_q;
    fmode_d = fmode_q;
    nbits_d = nbits_q;
    full_d = full_q;
    if (!full_q && res_valid && res_ready) begin
      full_d = 1'b1;
      ish_d = res_i;
      qsh_d = res_q;
    end
    if (tick) begin
      case (st_q)
        SOFP_ST_IDLE: begin
          if (go) begin
            fmode_d = sofp_fsmode_t'(ext_q[EXT_MODE_LSB +: 2]);
            nbits_d = sofp_word_bits(ext_q[EXT_WLEN_LSB +: 2]);
            cnt_d = 6'h00;
            st_d = (master && fmode_d == SOFP_FS_DURING) ? SOFP_ST_SHIFT
                                                         : SOFP_ST_SYNC;
          end
        end
        SOFP_ST_SYNC: st_d = SOFP_ST_SHIFT;
        SOFP_ST_SHIFT: begin
          if (cnt_q == last_idx) begin
            st_d = SOFP_ST_IDLE;
            full_d = 1'b0;
          end else begin
            cnt_d = cnt_q + 6'h01;
            // the Q word starts fresh, so neither shifts at the seam
            if (cnt_q < i_last) begin
              ish_d = {ish_q[22:0], 1'b0};
            end else if (cnt_q >= nb6) begin
              qsh_d = {qsh_q[22:0], 1'b0};
            end
          end
        end
        default: st_d = SOFP_ST_IDLE;
      endcase
    end
    nbd = {1'b0, nbits_d};
    sdo_n = (st_d == SOFP_ST_SHIFT) &&
            ((cnt_d >= nbd) ? qsh_d[23] : ish_d[23]);
    fe_n = (st_d == SOFP_ST_SHIFT) && (cnt_d == {nbits_d, 1'b0} - 6'h01);
    fs_n = master && ((st_d == SOFP_ST_SYNC) ||
           (st_d == SOFP_ST_SHIFT && fmode_d == SOFP_FS_DURING) ||
           (st_d == SOFP_ST_SHIFT && fmode_d == SOFP_FS_EACH &&
            cnt_d == nbd - 6'h01));
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= SOFP_ST_IDLE;
      fmode_q <= SOFP_FS_PRE;
      cnt_q <= 6'h00;
      nbits_q <= BITS_12;
      ish_q <= 24'h000000;
      qsh_q <= 24'h000000;
      full_q <= 1'b0;
    end else begin
      st_q <= st_d;
      fmode_q <= fmode_d;
      cnt_q <= cnt_d;
      nbits_q <= nbits_d;
      ish_q <= ish_d;
      qsh_q <= qsh_d;
      full_q <= full_d;
    end
  end
  // pins change only on sclk rising ticks
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      serial_data_out <= 1'b0;
      frame_end <= 1'b0;
      frame_sync_o <= 1'b0;
    end else if (tick) begin
      serial_data_out <= sdo_n;
      frame_end <= fe_n;
      frame_sync_o <= fs_n;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sclk_oe <= 1'b0;
      frame_sync_oe <= 1'b0;
      channel_data_ready <= 1'b0;
      res_ready <= 1'b0;
    end else begin
      sclk_oe <= master;
      frame_sync_oe <= master;
      channel_data_ready <= full_q;
      res_ready <= !full_d;
    end
  end

  function automatic logic [1:0] reg_sel(input logic [SOFP_AW-1:0] a);
    reg_sel = (a == ADDR_CFG) ? 2'h1 : (a == ADDR_EXT) ? 2'h2 :
              (a == ADDR_STAT) ? 2'h3 : 2'h0;
  endfunction

  wire [1:0] wsel = reg_sel(s_axi_awaddr);
  wire [1:0] rsel = reg_sel(s_axi_araddr);
  wire wr_fire = s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  wire rd_fire = s_axi_arvalid && s_axi_arready;
  wire [4:0] cfg_view = IS_PORT0 ? 5'h00 : cfg_q;
  wire [31:0] stat_word = {28'h0000000, st_q, master, full_q};
  wire [31:0] rd_word = (rsel == 2'h1) ? {27'h0000000, cfg_view} :
                        (rsel == 2'h2) ? {28'h0000000, ext_q} :
                        (rsel == 2'h3) ? stat_word : 32'h00000000;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      s_axi_awready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                       !s_axi_bvalid;
      s_axi_wready <= s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
                      !s_axi_bvalid;
      s_axi_bvalid <= wr_fire || (s_axi_bvalid && !s_axi_bready);
      if (wr_fire) begin
        s_axi_bresp <= (wsel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
      s_axi_arready <= s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
      s_axi_rvalid <= rd_fire || (s_axi_rvalid && !s_axi_rready);
      if (rd_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= (rsel == 2'h0) ? RESP_SLVERR : RESP_OKAY;
      end
    end
  end
  // port 0 ignores config writes; master and divider come from straps, frame options stay writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_q <= CFG_RST;
      ext_q <= EXT_RST;
    end else if (wr_fire && s_axi_wstrb[0]) begin
      if (wsel == 2'h1 && !IS_PORT0) begin
        cfg_q <= s_axi_wdata[4:0];
      end
      if (wsel == 2'h2) begin
        ext_q <= s_axi_wdata[3:0];
      end
    end
  end

  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ish_msb = ish_q[23];
  a_fe_last_bit: assert property (
    frame_end |-> st_q == SOFP_ST_SHIFT && cnt_q == last_idx)
    else $error("frame end outside the last Q bit");
  a_fs_during_shift: assert property (
    master && fmode_q == SOFP_FS_DURING && st_q == SOFP_ST_SHIFT
    |-> frame_sync_o)
    else $error("frame sync low while shifting in during mode");
  a_fs_each_word: assert property (
    master && frame_sync_o && fmode_q == SOFP_FS_EACH
    |-> st_q == SOFP_ST_SYNC || cnt_q == i_last)
    else $error("frame sync not before a word in each mode");
  sequence seq_sync_tick;
    tick && st_q == SOFP_ST_SYNC;
  endsequence
  a_shift_after_sync: assert property (
    seq_sync_tick |=> st_q == SOFP_ST_SHIFT && cnt_q == 6'h00)
    else $error("shift did not start after the sync period");
  a_msb_leads: assert property (
    tick && st_q == SOFP_ST_SYNC |=> serial_data_out == $past(ish_msb))
    else $error("first bit is not the I word msb");
  a_slave_sample: assert property (
    s_tick && st_q == SOFP_ST_IDLE && fs_in && full_q
    |=> st_q == SOFP_ST_SYNC)
    else $error("cascade sync not taken on sclk rise");
  a_ready_follows: assert property (
    full_q |=> channel_data_ready)
    else $error("data ready missing with buffer full");
  a_master_drives: assert property (
    master ##1 master |-> sclk_oe && frame_sync_oe)
    else $error("master not driving clock and sync");
  a_tick_spacing: assert property (
    m_tick |=> !m_tick)
    else $error("master clock ticks too close");
endmodule

// File: dv/sofp_dsp_model.sv
// dsp-side partner: samples one value per bit period, clocks slave frames
// assumes port outputs change once per serial clock tick
`timescale 1ns/1ps
module sofp_dsp_model (
  // clock and control
  input wire logic aclk,
  input wire logic slave_run,
  input wire logic [4:0] wbits,
  // port pins
  input wire logic sclk_o,
  input wire logic frame_sync_o,
  input wire logic serial_data_out,
  input wire logic frame_end,
  input wire logic channel_data_ready,
  output logic sclk_i,
  output logic frame_sync_i
);
  logic dq[$];
  logic fsq[$];
  logic feq[$];
  int per = 0;
  int cnt = 0;
  logic prev = 1'b0;
  task automatic grab();
    dq.push_back(serial_data_out);
    fsq.push_back(frame_sync_o);
    feq.push_back(frame_end);
  endtask
  // master: outputs are new at the edge after sclk_o rose
  always @(posedge aclk) begin
    if (!slave_run) begin
      if (sclk_o && !prev) begin
        per = cnt;
        cnt = 0;
        grab();
      end
      cnt = cnt + 1;
      prev = sclk_o;
    end
  end
  // clock stands low outside frames; halves of 5 cycles meet the minimum
  initial begin
    sclk_i = 1'b0;
    frame_sync_i = 1'b0;
    forever begin
      @(posedge aclk);
      if (slave_run && channel_data_ready === 1'b1) begin
        frame_sync_i <= 1'b1;
        repeat (5) @(posedge aclk);
        for (int k = 0; k < 2 * wbits + 2; k++) begin
          grab();
          sclk_i <= 1'b1;
          repeat (5) @(posedge aclk);
          sclk_i <= 1'b0;
          frame_sync_i <= 1'b0;
          repeat (5) @(posedge aclk);
        end
      end
    end
  end
endmodule

// File: dv/testbench.sv
// bench for the serial output frame port: registers, master, slave frames
// assumes sofp_dsp_model records one sample per serial bit period
`timescale 1ns/1ps
module testbench;
  import sofp_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [SOFP_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, res_valid = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, res_ready, sclk_i, sclk_o, sclk_oe, frame_sync_i;
  logic frame_sync_o, frame_sync_oe, serial_data_out, frame_end;
  logic channel_data_ready, slave_run = 1'b0;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [23:0] res_i = '0, res_q = '0;
  logic [3:0] dv;
  logic [4:0] wbits = BITS_12;
  int nb[3] = '{12, 16, 24};
  int fail_count = 0;
  int checks = 0;
  int ext;
  longint t0;
  logic [3:0] p0_div = 4'h0;
  logic p0_sclk, p0_oe;

  initial begin
    forever #2 aclk = ~aclk;
  end

  sofp_port #(.IS_PORT0(1'b0)) DUT (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .res_valid(res_valid), .res_i(res_i),
    .res_q(res_q), .res_ready(res_ready), .port0_master_pin(1'b0),
    .port0_divider_pins(4'h0), .sclk_i(sclk_i), .sclk_o(sclk_o),
    .sclk_oe(sclk_oe), .frame_sync_i(frame_sync_i),
    .frame_sync_o(frame_sync_o), .frame_sync_oe(frame_sync_oe),
    .serial_data_out(serial_data_out), .frame_end(frame_end),
    .channel_data_ready(channel_data_ready));

  sofp_dsp_model P (.aclk(aclk), .slave_run(slave_run), .wbits(wbits),
    .sclk_o(sclk_o), .frame_sync_o(frame_sync_o),
    .serial_data_out(serial_data_out), .frame_end(frame_end),
    .channel_data_ready(channel_data_ready), .sclk_i(sclk_i),
    .frame_sync_i(frame_sync_i));

  // port 0 flavour: master and divider come only from its straps
  sofp_port #(.IS_PORT0(1'b1)) DUT0 (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(10'h000), .s_axi_awvalid(1'b0), .s_axi_awready(),
    .s_axi_wdata(32'h00000000), .s_axi_wstrb(4'h0), .s_axi_wvalid(1'b0),
    .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready(1'b0),
    .s_axi_araddr(10'h000), .s_axi_arvalid(1'b0), .s_axi_arready(),
    .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready(1'b0),
    .res_valid(1'b0), .res_i(24'h000000), .res_q(24'h000000),
    .res_ready(), .port0_master_pin(1'b1), .port0_divider_pins(p0_div),
    .sclk_i(1'b0), .sclk_o(p0_sclk), .sclk_oe(p0_oe),
    .frame_sync_i(1'b0), .frame_sync_o(), .frame_sync_oe(),
    .serial_data_out(), .frame_end(), .channel_data_ready());

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: word %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: bit %b, wanted %b", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [9:0] a, input logic [31:0] d);
    int n = 0;
    logic aw = 1'b1;
    logic w = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // each channel is released at the edge where its own ready is seen
    while ((aw || w) && n++ < 200) begin
      @(posedge aclk);
      if (s_axi_awready === 1'b1) aw = 1'b0;
      if (s_axi_wready === 1'b1) w = 1'b0;
      s_axi_awvalid <= aw;
      s_axi_wvalid <= w;
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1 && n++ < 400);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    chk_bit(n < 400, 1'b1);
    @(posedge aclk);
  endtask

  task automatic rd_reg(input logic [9:0] a);
    int n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1 && n++ < 200);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1 && n++ < 400);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk_bit(n < 400, 1'b1);
    @(posedge aclk);
  endtask

  // one result through the port, then the recorded frame against the rules
  task automatic frame(input int m, input int n, input logic mst);
    logic [23:0] i, q;
    int e, t, s;
    i = 24'($urandom());
    q = 24'($urandom());
    t = 0;
    e = -1;
    P.dq.delete();
    P.fsq.delete();
    P.feq.delete();
    while (res_ready !== 1'b1 && t++ < 5000) @(posedge aclk);
    res_i <= i;
    res_q <= q;
    res_valid <= 1'b1;
    do @(posedge aclk); while (res_ready !== 1'b1 && t++ < 5000);
    res_valid <= 1'b0;
    @(posedge aclk);
    @(posedge aclk);
    #1;
    chk_bit(channel_data_ready, 1'b1);
    while (e < 0 && t++ < 20000) begin
      @(posedge aclk);
      if (P.feq.size() > 0 && P.feq[$] === 1'b1) e = P.feq.size() - 1;
    end
    s = e - 2 * n + 1;
    chk_bit(s >= 0, 1'b1);
    for (int b = 0; b < 2 * n && s >= 0; b++) begin
      chk_bit(P.dq[s + b], b < n ? i[23 - b] : q[23 - b + n]);
      chk_bit(P.feq[s + b], b == 2 * n - 1);
      if (mst) chk_bit(P.fsq[s + b], m == 1 || (m == 2 && b == n - 1));
    end
    if (mst && s > 0) chk_bit(P.fsq[s - 1], m != 1);
    repeat (40) @(posedge aclk);
  endtask

  initial begin
    #200000;
    fail_count++;
    $display("unexpected at %0t: run stalled", $time);
    final_report();
  end

  initial begin
    void'($urandom(32'h36a6b1d6));
    p0_div <= 4'($urandom_range(0, 15));
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_reg(ADDR_CFG);
    chk_word(rd, 32'h0);
    chk_bit(sclk_oe | frame_sync_oe, 1'b0);
    rd_reg(10'h000);
    chk_word({rd[29:0], resp}, {30'h0, RESP_SLVERR});
    wr_reg(10'h3fc, 32'h0);
    chk_word(32'(resp), 32'(RESP_SLVERR));
    $display("test registers done");
    chk_bit(p0_oe, 1'b1);
    @(posedge p0_sclk);
    t0 = $time;
    @(posedge p0_sclk);
    ext = (p0_div == 4'h0) ? 2 : p0_div + 1;
    chk_word(32'(($time - t0) / 4), 32'(ext));
    $display("test port zero straps done");
    for (int m = 0; m < 3; m++) begin
      for (int w = 0; w < 3; w++) begin
        dv = 4'($urandom_range(0, 15));
        wr_reg(ADDR_CFG, {27'h0, 1'b1, dv});
        // codes 3 stand for 24 bits and for pre-sync timing
        ext = w * 4 + m;
        if (w == 2) ext = ext | 4 * int'($urandom_range(0, 1));
        if (m == 0) ext = ext | 3 * int'($urandom_range(0, 1));
        wr_reg(ADDR_EXT, 32'(ext));
        rd_reg(ADDR_CFG);
        chk_word(rd, {27'h0, 1'b1, dv});
        rd_reg(ADDR_STAT);
        chk_bit(rd[STAT_MASTER_BIT], 1'b1);
        chk_bit(sclk_oe & frame_sync_oe, 1'b1);
        frame(m, nb[w], 1'b1);
        chk_word(32'(P.per), dv == 4'h0 ? 32'd2 : 32'(dv) + 1);
        $display("test master mode %0d width %0d done", m, nb[w]);
      end
    end
    slave_run <= 1'b1;
    wbits <= BITS_16;
    wr_reg(ADDR_CFG, 32'h0);
    wr_reg(ADDR_EXT, 32'h4);
    rd_reg(ADDR_STAT);
    chk_bit(rd[STAT_MASTER_BIT] | sclk_oe | frame_sync_oe, 1'b0);
    frame(0, 16, 1'b0);
    $display("test cascade frame done");
    final_report();
  end
endmodule
